// [core/ssc_counter.sv]
// Scaled system counter with Avalon-MM register slave.
`timescale 1ns/10ps
module ssc_counter #(
	parameter int DIV_W = 16,
	parameter logic [15:0] TICK_DIV = 16'h0000,
	parameter bit SCALING_IMPL = 1'b1
) (
	// Clock and reset.
	input wire logic ref_clk,
	input wire logic rst_n,
	// Avalon-MM slave.
	input wire logic [ssc_pkg::ADDR_W-1:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	// Distributed count.
	output ssc_pkg::ssc_count_t gen_count,
	output logic [ssc_pkg::INT_W-1:0] count_value_reg
);
	ssc_pkg::ssc_ctrl_t ctrl;
	logic [ssc_pkg::SCALE_W-1:0] count_scale_value;
	logic [ssc_pkg::CNT_W-1:0] count;
	logic tick;
	logic [ssc_pkg::SCALE_W-1:0] increment_amount;
	logic [ssc_pkg::CNT_W-1:0] next_count;
	ssc_pkg::ssc_bus_st_t bus_st;
	logic acc;
	logic wr_go;
	logic [31:0] next_rdata;
	logic [31:0] wmask;
	logic wr_cv_lo;
	logic wr_cv_hi;

	initial begin
		if (DIV_W > 16 || DIV_W < 1) begin
			$error("DIV_W must lie between 1 and 16.");
		end
	end

	// Tick source for the counter.
	ssc_tick_gen #(
		.DIV_W(DIV_W)
	) u_tick (
		.ref_clk(ref_clk),
		.rst_n(rst_n),
		.run(ctrl.count_enable),
		.divide(TICK_DIV[DIV_W-1:0]),
		.tick(tick)
	);

	// Byte enables expand to a bit mask.
	genvar gi;
	generate
		for (gi = 0; gi < 4; gi++) begin : g_mask
			assign wmask[gi*8 +: 8] = {8{avs_byteenable[gi]}};
		end
	endgenerate

	// The slave answers a request two cycles after it is first seen.
	assign acc = avs_read || avs_write;
	assign avs_waitrequest = acc && (bus_st != ssc_pkg::SSC_DONE);
	assign wr_go = avs_write && (bus_st == ssc_pkg::SSC_DONE);
	assign wr_cv_lo = wr_go && (avs_address == ssc_pkg::OFS_CV_LO);
	assign wr_cv_hi = wr_go && (avs_address == ssc_pkg::OFS_CV_HI);

	// Bus handshake state.
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			bus_st <= ssc_pkg::SSC_IDLE;
		end else begin
			case (bus_st)
				ssc_pkg::SSC_IDLE: begin
					if (acc) begin
						bus_st <= ssc_pkg::SSC_FETCH;
					end
				end
				ssc_pkg::SSC_FETCH: begin
					bus_st <= ssc_pkg::SSC_DONE;
				end
				ssc_pkg::SSC_DONE: begin
					bus_st <= ssc_pkg::SSC_IDLE;
				end
				default: begin
					bus_st <= ssc_pkg::SSC_IDLE;
				end
			endcase
		end
	end

	// Read multiplexer; unmapped and reserved bits read zero.
	always_comb begin
		next_rdata = ssc_pkg::UNMAPPED_VAL;
		case (avs_address)
			ssc_pkg::OFS_CTRL: begin
				next_rdata[ssc_pkg::CTRL_EN_BIT] = ctrl.count_enable;
				next_rdata[ssc_pkg::CTRL_SCALE_ENABLE_BIT_BIT] = ctrl.scale_enable_bit;
			end
			ssc_pkg::OFS_CV_LO: begin
				next_rdata = count[ssc_pkg::FRAC_W +: 32];
			end
			ssc_pkg::OFS_CV_HI: begin
				next_rdata = count[ssc_pkg::FRAC_W+32 +: 32];
			end
			ssc_pkg::OFS_SCALE: begin
				next_rdata = count_scale_value;
			end
			ssc_pkg::OFS_CAP: begin
				next_rdata[3:0] = SCALING_IMPL ? ssc_pkg::CAP_SCALING
					: ssc_pkg::CAP_NONE;
			end
			ssc_pkg::OFS_CID0: begin
				next_rdata[7:0] = ssc_pkg::CID0_VAL;
			end
			ssc_pkg::OFS_CID1: begin
				next_rdata[7:0] = {ssc_pkg::CID1_CLASS,
					ssc_pkg::CID1_PRMBL};
			end
			ssc_pkg::OFS_CID2: begin
				next_rdata[7:0] = ssc_pkg::CID2_VAL;
			end
			ssc_pkg::OFS_CID3: begin
				next_rdata[7:0] = ssc_pkg::CID3_VAL;
			end
			default: begin
				next_rdata = ssc_pkg::UNMAPPED_VAL;
			end
		endcase
	end

	// Read data is registered in the fetch cycle.
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			avs_readdata <= '0;
		end else if (avs_read && bus_st == ssc_pkg::SSC_FETCH) begin
			avs_readdata <= next_rdata;
		end
	end

	// Control register; only enable and scale enable bits are held.
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			ctrl <= '0;
		end else if (wr_go && avs_address == ssc_pkg::OFS_CTRL &&
			avs_byteenable[0]) begin
			ctrl.count_enable <= avs_writedata[ssc_pkg::CTRL_EN_BIT];
			ctrl.scale_enable_bit <=
				avs_writedata[ssc_pkg::CTRL_SCALE_ENABLE_BIT_BIT] && SCALING_IMPL;
		end
	end

	// Scale register; software changes it only while stopped.
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			count_scale_value <= ssc_pkg::SCALE_RST;
		end else if (wr_go && avs_address == ssc_pkg::OFS_SCALE) begin
			count_scale_value <= (count_scale_value & ~wmask)
				| (avs_writedata & wmask);
		end
	end

	// Increment select: unit step, or the 8.24 scale value.
	assign increment_amount = ctrl.scale_enable_bit ? count_scale_value
		: ssc_pkg::SCALE_ONE;

	// Full-width add so fraction overflow carries into the integer.
	assign next_count = count + {{(ssc_pkg::CNT_W-ssc_pkg::SCALE_W){1'b0}},
		increment_amount};

	// Count accumulator; a count value write clears the fraction.
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			count <= '0;
		end else if (wr_cv_lo || wr_cv_hi) begin
			if (wr_cv_lo) begin
				count[ssc_pkg::FRAC_W +: 32] <=
					(count[ssc_pkg::FRAC_W +: 32] & ~wmask)
					| (avs_writedata & wmask);
			end
			if (wr_cv_hi) begin
				count[ssc_pkg::FRAC_W+32 +: 32] <=
					(count[ssc_pkg::FRAC_W+32 +: 32] & ~wmask)
					| (avs_writedata & wmask);
			end
			count[ssc_pkg::FRAC_W-1:0] <= '0;
		end else if (tick && ctrl.count_enable) begin
			count <= next_count;
		end
	end

	// Every presented copy is the same plain binary scaled count.
	assign gen_count = count;
	assign count_value_reg = count[ssc_pkg::CNT_W-1:ssc_pkg::FRAC_W];

	// Cycles since the last tick; only the tick spacing check reads it.
	logic [DIV_W:0] tick_gap;
	logic tick_seen;
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			tick_gap <= '0;
			tick_seen <= 1'b0;
		end else if (!ctrl.count_enable) begin
			tick_gap <= '0;
			tick_seen <= 1'b0;
		end else if (tick) begin
			tick_gap <= '0;
			tick_seen <= 1'b1;
		end else begin
			tick_gap <= tick_gap + 1'b1;
		end
	end

	// Assertions on the count path.
	fraction_clear_a: assert property (
		@(posedge ref_clk) disable iff (!rst_n)
		(wr_cv_lo || wr_cv_hi) |=> count[ssc_pkg::FRAC_W-1:0] == '0)
		else $error("Fraction not cleared after count write.");
	step_unit_a: assert property (
		@(posedge ref_clk) disable iff (!rst_n)
		(tick && ctrl.count_enable && !ctrl.scale_enable_bit
		&& !wr_cv_lo && !wr_cv_hi)
		|=> count == $past(count) + ssc_pkg::CNT_W'(ssc_pkg::SCALE_ONE))
		else $error("Unscaled step is not one.");
	step_scale_a: assert property (
		@(posedge ref_clk) disable iff (!rst_n)
		(tick && ctrl.count_enable && ctrl.scale_enable_bit
		&& !wr_cv_lo && !wr_cv_hi)
		|=> count == $past(count)
		+ ssc_pkg::CNT_W'($past(count_scale_value)))
		else $error("Scaled step is wrong.");
	hold_stopped_a: assert property (
		@(posedge ref_clk) disable iff (!rst_n)
		(!ctrl.count_enable && !wr_go) |=> $stable(count))
		else $error("Count moved while disabled.");

	// A fraction sum past its top must lift the integer one extra step.
	sequence carry_tick_s;
		tick && ctrl.count_enable && !wr_cv_lo && !wr_cv_hi
		&& ({1'b0, count[ssc_pkg::FRAC_W-1:0]}
		+ {1'b0, increment_amount[ssc_pkg::FRAC_W-1:0]})
		> {1'b0, {ssc_pkg::FRAC_W{1'b1}}};
	endsequence
	frac_carry_a: assert property (
		@(posedge ref_clk) disable iff (!rst_n)
		carry_tick_s |=> gen_count.whole == $past(gen_count.whole)
		+ ssc_pkg::INT_W'($past(increment_amount) >> ssc_pkg::FRAC_W)
		+ 1'b1)
		else $error("Fraction carry lost.");

	// The tick source stays quiet while stopped and keeps its spacing.
	tick_gate_a: assert property (
		@(posedge ref_clk) disable iff (!rst_n)
		!ctrl.count_enable |=> !tick)
		else $error("Tick while counter disabled.");
	tick_space_a: assert property (
		@(posedge ref_clk) disable iff (!rst_n)
		(tick && tick_seen && ctrl.count_enable)
		|-> tick_gap == {1'b0, TICK_DIV[DIV_W-1:0]})
		else $error("Tick spacing wrong.");

	// Register reads return what the logic held one cycle before.
	sequence rd_lo_s;
		avs_read && avs_address == ssc_pkg::OFS_CV_LO && !avs_waitrequest;
	endsequence
	int_out_a: assert property (
		@(posedge ref_clk) disable iff (!rst_n)
		rd_lo_s |-> avs_readdata == $past(count_value_reg[31:0]))
		else $error("Integer low word read mismatch.");
	sequence rd_hi_s;
		avs_read && avs_address == ssc_pkg::OFS_CV_HI && !avs_waitrequest;
	endsequence
	cv_hi_read_a: assert property (
		@(posedge ref_clk) disable iff (!rst_n)
		rd_hi_s |-> avs_readdata == $past(count_value_reg[63:32]))
		else $error("Integer high word read mismatch.");
	sequence rd_scale_s;
		avs_read && avs_address == ssc_pkg::OFS_SCALE && !avs_waitrequest;
	endsequence
	scale_read_a: assert property (
		@(posedge ref_clk) disable iff (!rst_n)
		rd_scale_s |-> avs_readdata == $past(count_scale_value))
		else $error("Scale read wrong.");
	sequence rd_ctrl_s;
		avs_read && avs_address == ssc_pkg::OFS_CTRL && !avs_waitrequest;
	endsequence
	ctrl_read_a: assert property (
		@(posedge ref_clk) disable iff (!rst_n)
		rd_ctrl_s |-> avs_readdata == {29'h0000000,
		$past(ctrl.scale_enable_bit), 1'b0, $past(ctrl.count_enable)})
		else $error("Control read wrong.");
	sequence rd_cap_s;
		avs_read && avs_address == ssc_pkg::OFS_CAP && !avs_waitrequest;
	endsequence
	cap_read_a: assert property (
		@(posedge ref_clk) disable iff (!rst_n)
		rd_cap_s |-> avs_readdata == {28'h0000000, ssc_pkg::CAP_SCALING})
		else $error("Capability read wrong.");
	cid1_read_a: assert property (
		@(posedge ref_clk) disable iff (!rst_n)
		(avs_read && avs_address == ssc_pkg::OFS_CID1 && !avs_waitrequest)
		|-> avs_readdata == 32'h0000_00f0)
		else $error("Ident 1 read wrong.");
	cid3_read_a: assert property (
		@(posedge ref_clk) disable iff (!rst_n)
		(avs_read && avs_address == ssc_pkg::OFS_CID3 && !avs_waitrequest)
		|-> avs_readdata == 32'h0000_00b1)
		else $error("Ident 3 read wrong.");
	cid0_read_a: assert property (
		@(posedge ref_clk) disable iff (!rst_n)
		(avs_read && avs_address == ssc_pkg::OFS_CID0 && !avs_waitrequest)
		|-> avs_readdata == 32'h0000_000d)
		else $error("Ident 0 read wrong.");
	cid2_read_a: assert property (
		@(posedge ref_clk) disable iff (!rst_n)
		(avs_read && avs_address == ssc_pkg::OFS_CID2 && !avs_waitrequest)
		|-> avs_readdata == 32'h0000_0005)
		else $error("Ident 2 read wrong.");

	// Register writes land on the answering edge, once.
	ctrl_write_a: assert property (
		@(posedge ref_clk) disable iff (!rst_n)
		(wr_go && avs_address == ssc_pkg::OFS_CTRL && avs_byteenable[0])
		|=> ctrl.count_enable == $past(avs_writedata[ssc_pkg::CTRL_EN_BIT]))
		else $error("Enable write not taken.");
	cv_write_a: assert property (
		@(posedge ref_clk) disable iff (!rst_n)
		(wr_cv_lo && avs_byteenable == 4'hf)
		|=> count_value_reg[31:0] == $past(avs_writedata))
		else $error("Low count word write not taken.");
	cv_hi_write_a: assert property (
		@(posedge ref_clk) disable iff (!rst_n)
		(wr_cv_hi && avs_byteenable == 4'hf)
		|=> count_value_reg[ssc_pkg::INT_W-1:32] == $past(avs_writedata))
		else $error("High count word write not taken.");
	write_once_a: assert property (
		@(posedge ref_clk) disable iff (!rst_n)
		wr_go |=> !wr_go)
		else $error("Write applied twice.");

	// Handshake timing: answer on the third cycle, standing for one.
	sequence req_s;
		acc && bus_st == ssc_pkg::SSC_IDLE;
	endsequence
	wait_len_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
		req_s |-> avs_waitrequest ##1 avs_waitrequest ##1 !avs_waitrequest)
		else $error("Bus answer not on third cycle.");
	wait_stand_a: assert property (
		@(posedge ref_clk) disable iff (!rst_n)
		(acc && !avs_waitrequest) |=> (!acc || avs_waitrequest))
		else $error("Answer stood more than one cycle.");
	idle_quiet_a: assert property (
		@(posedge ref_clk) disable iff (!rst_n)
		!acc |-> !avs_waitrequest)
		else $error("Wait raised with no request.");
endmodule

// [core/ssc_pkg.sv]
// Package with register map, field layout and types of the scaled counter.
// Contract
// - Count is 88-bit fixed point: 64 integer bits, 24 fraction bits.
// - Integer part is read from count value register and distributed.
// - Scale value is added per tick only while scaling is enabled.
// - Scale value is unsigned 8.24 fixed point.
// - One tick per period of the current operating frequency.
// - Writing count value register clears the fraction to zero.
// - Count distributed as plain binary, never Gray coded.
// - Scaling applies to every presented copy of the count.
// - Capability register at 0x1c bits [3:0] report scaling support.
// - Component ident 0 at 0xff0 returns 0x0d.
// - Component ident 1 at 0xff4 returns class 0xf in [7:4].
// - Component ident 2 at 0xff8 returns 0x05.
// - Component ident 3 at 0xffc returns 0xb1.
// - Scale enable bit [2]: clear adds one, set adds scale value.
// - Counter enable bit [0] starts and stops counting, resets zero.
package ssc_pkg;
	localparam int ADDR_W = 12;
	localparam int INT_W = 64;
	localparam int FRAC_W = 24;
	localparam int CNT_W = INT_W + FRAC_W;
	localparam int SCALE_W = 32;
	localparam int SCALE_INT_W = 8;
	localparam int REG_CNT = 9;
	// Register byte offsets.
	localparam logic [11:0] OFS_CTRL = 12'h000;
	localparam logic [11:0] OFS_CV_LO = 12'h008;
	localparam logic [11:0] OFS_CV_HI = 12'h00c;
	localparam logic [11:0] OFS_SCALE = 12'h010;
	localparam logic [11:0] OFS_CAP = 12'h01c;
	localparam logic [11:0] OFS_CID0 = 12'hff0;
	localparam logic [11:0] OFS_CID1 = 12'hff4;
	localparam logic [11:0] OFS_CID2 = 12'hff8;
	localparam logic [11:0] OFS_CID3 = 12'hffc;
	// Control field positions.
	localparam int CTRL_EN_BIT = 0;
	localparam int CTRL_SCALE_ENABLE_BIT_BIT = 2;
	// Fixed read values.
	localparam logic [3:0] CAP_NONE = 4'h0;
	localparam logic [3:0] CAP_SCALING = 4'h1;
	localparam logic [7:0] CID0_VAL = 8'h0d;
	localparam logic [3:0] CID1_CLASS = 4'hf;
	localparam logic [3:0] CID1_PRMBL = 4'h0;
	localparam logic [7:0] CID2_VAL = 8'h05;
	localparam logic [7:0] CID3_VAL = 8'hb1;
	localparam logic [31:0] UNMAPPED_VAL = 32'h0000_0000;
	// Unit increment in 8.24 form, used while scaling is off.
	localparam logic [31:0] SCALE_ONE = 32'h0100_0000;
	localparam logic [31:0] SCALE_RST = 32'h0100_0000;
	// Bus transaction state machine.
	typedef enum logic [2:0] {
		SSC_IDLE = 3'b001,
		SSC_FETCH = 3'b010,
		SSC_DONE = 3'b100
	} ssc_bus_st_t;
	// Control register content.
	typedef struct packed {
		logic scale_enable_bit;
		logic count_enable;
	} ssc_ctrl_t;
	// Distributed count, integer and fraction together.
	typedef struct packed {
		logic [INT_W-1:0] whole;
		logic [FRAC_W-1:0] frac;
	} ssc_count_t;
endpackage

// [core/ssc_tick_gen.sv]
// Tick divider that yields one enable pulse per operating period.
`timescale 1ns/10ps
module ssc_tick_gen #(
	parameter int DIV_W = 16
) (
	// Clock and reset.
	input wire logic ref_clk,
	input wire logic rst_n,
	// Control.
	input wire logic run,
	input wire logic [DIV_W-1:0] divide,
	// Tick.
	output logic tick
);
	logic [DIV_W-1:0] cnt;

	initial begin
		if (DIV_W < 1) begin
			$error("DIV_W must be at least one.");
		end
	end

	// Counts reference cycles; divide of zero means tick every cycle.
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			cnt <= '0;
			tick <= 1'b0;
		end else if (!run) begin
			cnt <= '0;
			tick <= 1'b0;
		end else if (cnt >= divide) begin
			cnt <= '0;
			tick <= 1'b1;
		end else begin
			cnt <= cnt + 1'b1;
			tick <= 1'b0;
		end
	end
endmodule

// [dv/scaled_system_counter_tb_top.sv]
// Self-checking testbench for the scaled counter with its register slave.
`timescale 1ns/10ps
module scaled_system_counter_tb_top;
	typedef struct packed {
		logic [11:0] a;
		logic wr;
		logic [31:0] wd;
		logic [31:0] ex;
	} ssc_row_t;
	logic ref_clk = 1'b0;
	logic rst_n = 1'b0;
	logic [11:0] avs_address = 12'h000;
	logic avs_read = 1'b0;
	logic avs_write = 1'b0;
	logic [31:0] avs_writedata = 32'h0000_0000;
	logic [3:0] avs_byteenable = 4'hf;
	logic [31:0] avs_readdata;
	logic avs_waitrequest;
	ssc_pkg::ssc_count_t gen_count;
	logic [63:0] count_value_reg;
	int err_total = 0;
	int checked = 0;
	int ticks = 0;
	logic mon_on = 1'b0;
	logic [87:0] prv = 88'h0;
	logic [87:0] exp_inc = 88'h0;
	logic [31:0] rd;
	// Plain register cases: address, write flag, write data, expected read.
	ssc_row_t rows[10] = '{
		'{12'hff0, 1'b0, 32'h0, 32'h0000_000d},
		'{12'hff4, 1'b0, 32'h0, 32'h0000_00f0},
		'{12'hff8, 1'b0, 32'h0, 32'h0000_0005},
		'{12'hffc, 1'b0, 32'h0, 32'h0000_00b1},
		'{12'h01c, 1'b0, 32'h0, 32'h0000_0001},
		'{12'hff0, 1'b1, 32'hffff_ffff, 32'h0000_000d},
		'{12'hff4, 1'b1, 32'h0000_0000, 32'h0000_00f0},
		'{12'h01c, 1'b1, 32'hffff_fff0, 32'h0000_0001},
		'{12'h010, 1'b1, 32'h1234_5678, 32'h1234_5678},
		'{12'h100, 1'b1, 32'hdead_beef, 32'h0000_0000}};
	// Control value, scale value and expected increment per tick.
	logic [31:0] sc_ctrl[4] = '{32'h1, 32'h5, 32'h5, 32'h5};
	logic [31:0] sc_val[4] = '{32'h0080_0000, 32'h0080_0000,
		32'hff00_0001, 32'h0000_0003};
	logic [31:0] sc_inc[4] = '{32'h0100_0000, 32'h0080_0000,
		32'hff00_0001, 32'h0000_0003};

	ssc_counter #(.TICK_DIV(16'h0000), .SCALING_IMPL(1'b1)) i_dut (
		.ref_clk(ref_clk), .rst_n(rst_n), .avs_address(avs_address),
		.avs_read(avs_read), .avs_write(avs_write),
		.avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
		.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
		.gen_count(gen_count), .count_value_reg(count_value_reg));

	// Free running 100 MHz clock.
	always #5 ref_clk = ~ref_clk;

	// Every change of the count while watched must be one whole increment.
	always @(posedge ref_clk) begin
		if (mon_on && (gen_count - prv) !== 88'h0) begin
			chk(gen_count - prv, exp_inc);
			ticks++;
		end
		prv = gen_count;
	end

	// Records one comparison and reports a mismatch at once.
	task automatic chk(input logic [87:0] got, input logic [87:0] ex);
		checked++;
		if (got !== ex) begin
			err_total++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, ex);
		end
	endtask

	// Holds the request until waitrequest is sampled low at an edge.
	task automatic bus(input logic [11:0] a, input logic wr,
		input logic [31:0] wd, output logic [31:0] d);
		int n;
		n = 0;
		@(posedge ref_clk);
		avs_address <= a;
		avs_read <= ~wr;
		avs_write <= wr;
		avs_writedata <= wd;
		do begin
			@(posedge ref_clk);
			n++;
		end while (avs_waitrequest !== 1'b0 && n < 50);
		d = avs_readdata;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
		if (n >= 50) begin
			err_total++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, n, 0);
		end
	endtask

	// Checks the state that reset must leave behind.
	task automatic reset_chk();
		chk(gen_count, 88'h0);
		bus(ssc_pkg::OFS_CTRL, 1'b0, 32'h0, rd);
		chk(rd, 32'h0);
		bus(ssc_pkg::OFS_SCALE, 1'b0, 32'h0, rd);
		chk(rd, ssc_pkg::SCALE_RST);
	endtask

	// Runs the counter in one mode from zero and checks the end count.
	task automatic run_mode(input logic [31:0] c, input logic [31:0] s,
		input logic [31:0] inc);
		logic [87:0] ex;
		time t_on;
		time t_off;
		bus(ssc_pkg::OFS_CTRL, 1'b1, 32'h0, rd);
		bus(ssc_pkg::OFS_CV_HI, 1'b1, 32'h0, rd);
		bus(ssc_pkg::OFS_CV_LO, 1'b1, 32'h0, rd);
		bus(ssc_pkg::OFS_SCALE, 1'b1, s, rd);
		exp_inc = {56'h0, inc};
		ticks = 0;
		mon_on = 1'b1;
		bus(ssc_pkg::OFS_CTRL, 1'b1, c, rd);
		t_on = $time;
		repeat (30) @(posedge ref_clk);
		bus(ssc_pkg::OFS_CTRL, 1'b0, 32'h0, rd);
		chk(rd, c);
		bus(ssc_pkg::OFS_CTRL, 1'b1, 32'h0, rd);
		t_off = $time;
		repeat (3) @(posedge ref_clk);
		mon_on = 1'b0;
		ex = 88'(ticks) * {56'h0, inc};
		// One tick a cycle: first two cycles after enable lands, last on stop.
		chk(88'(ticks), 88'((t_off - t_on) / 10 - 1));
		chk(gen_count, ex);
		chk(count_value_reg, ex[87:24]);
		bus(ssc_pkg::OFS_CV_HI, 1'b0, 32'h0, rd);
		chk(rd, ex[87:56]);
	endtask

	// Prints the counts and the verdict, then ends the run.
	task automatic end_sim();
		$display("comparisons %0d mismatches %0d", checked, err_total);
		if (err_total == 0 && checked > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	// Cuts a hang short well beyond the expected run length.
	initial begin
		repeat (20000) @(posedge ref_clk);
		err_total++;
		end_sim();
	end

	// Main sequence.
	initial begin
		repeat (6) @(posedge ref_clk);
		rst_n <= 1'b1;
		reset_chk();
		$display("test reset done");
		foreach (rows[i]) begin
			if (rows[i].wr)
				bus(rows[i].a, 1'b1, rows[i].wd, rd);
			bus(rows[i].a, 1'b0, 32'h0, rd);
			chk(rd, rows[i].ex);
		end
		$display("test registers done");
		foreach (sc_ctrl[i])
			run_mode(sc_ctrl[i], sc_val[i], sc_inc[i]);
		$display("test counting done");
		chk(88'(gen_count.frac !== 24'h0), 88'h1);
		bus(ssc_pkg::OFS_CV_HI, 1'b1, 32'ha5a5_a5a5, rd);
		#1;
		chk(gen_count.frac, 88'h0);
		bus(ssc_pkg::OFS_CV_LO, 1'b1, 32'h5a5a_5a5a, rd);
		#1;
		chk(gen_count, {64'ha5a5_a5a5_5a5a_5a5a, 24'h0});
		bus(ssc_pkg::OFS_CV_LO, 1'b0, 32'h0, rd);
		chk(rd, 32'h5a5a_5a5a);
		$display("test fraction clear done");
		avs_byteenable <= 4'h1;
		bus(ssc_pkg::OFS_SCALE, 1'b1, 32'hffff_ffff, rd);
		avs_byteenable <= 4'hf;
		bus(ssc_pkg::OFS_SCALE, 1'b0, 32'h0, rd);
		chk(rd, 32'h0000_00ff);
		$display("test byte lanes done");
		bus(ssc_pkg::OFS_CTRL, 1'b1, 32'h1, rd);
		repeat (5) @(posedge ref_clk);
		rst_n <= 1'b0;
		repeat (2) @(posedge ref_clk);
		rst_n <= 1'b1;
		reset_chk();
		$display("test second reset done");
		end_sim();
	end
endmodule
